//--- hw/iop_pkg.sv
// Constants and types shared by the configurable I/O port block.
// Assumes a 100 MHz core clock and a 32-bit AXI4-Lite register bus.
package iop_pkg;

   // Register indices; the byte address is four times the index.
   localparam logic [7:0] IDX_P1_LATCH   = 8'h90;
   localparam logic [7:0] IDX_P2_LATCH   = 8'hA0;
   localparam logic [7:0] IDX_P3_LATCH   = 8'hB0;
   localparam logic [7:0] IDX_P4_MODE_LO = 8'hBE;
   localparam logic [7:0] IDX_P4_MODE_HI = 8'hBF;
   localparam logic [7:0] IDX_P4_LATCH   = 8'hC0;
   localparam logic [7:0] IDX_P1_MODE_LO = 8'hC2;
   localparam logic [7:0] IDX_P1_MODE_HI = 8'hC3;
   localparam logic [7:0] IDX_P2_MODE_LO = 8'hC4;
   localparam logic [7:0] IDX_P2_MODE_HI = 8'hC5;
   localparam logic [7:0] IDX_P3_MODE_LO = 8'hC6;
   localparam logic [7:0] IDX_P3_MODE_HI = 8'hC7;
   localparam logic [7:0] IDX_CTRL       = 8'hD0;
   localparam logic [7:0] IDX_GPI_EN     = 8'hD1;

   // Address bit that selects the latch readback alias of a latch.
   localparam int ALIAS_BIT = 10;
   localparam int ADDR_W    = 12;

   // Control register fields.
   localparam int CTRL_CMP_A = 0;
   localparam int CTRL_CMP_B = 1;
   localparam int CTRL_PDOWN = 2;

   // Pin masks over the flat 32-pin vector, port 1 in bits 7:0.
   localparam logic [31:0] WAKE_PIN_MASK   = 32'h034C_0000;
   localparam logic [31:0] ANALOG_PIN_MASK = 32'h0000_F000;

   // Reset values.
   localparam logic [31:0] LATCH_RST       = 32'hFFFF_FFFF;
   localparam logic [31:0] MODE_LO_RST_TRI = 32'hFFFF_FFFF;
   localparam logic [31:0] MODE_LO_RST_QB  = ANALOG_PIN_MASK;
   localparam logic [31:0] MODE_HI_RST     = 32'h0000_0000;
   localparam logic [7:0]  CTRL_RST        = 8'h00;
   localparam logic [7:0]  GPI_EN_RST      = 8'h00;

   // Strong pull-up pulse after a latch rise in quasi mode.
   localparam int STRONG_NS = 20;
   localparam int CLK_NS    = 10;
   localparam logic [1:0] STRONG_CYCLES =
      2'((STRONG_NS + CLK_NS - 1) / CLK_NS);

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      MODE_QUASI,
      MODE_PUSH_PULL,
      MODE_INPUT_ONLY,
      MODE_OPEN_DRAIN
   } iop_mode_e;

   typedef enum logic [2:0] {
      KIND_NONE,
      KIND_LATCH,
      KIND_MODE_LO,
      KIND_MODE_HI,
      KIND_CTRL,
      KIND_GPI
   } iop_kind_e;

   // Per-pin pad controls, one bit per pin in each field.
   typedef struct packed {
      logic [31:0] strong_pu;
      logic [31:0] weak_pu;
      logic [31:0] very_weak_pu;
      logic [31:0] pull_down;
      logic [31:0] input_en;
   } iop_pad_s;

endpackage

//--- hw/iop_port.sv
// Four 8-bit configurable I/O ports with an AXI4-Lite register slave.
// Assumes pad cells driven by pad_ctrl and pins sensed on pin_level.
`timescale 1ns/1ps
`default_nettype none

module iop_port (
   input  wire  logic                       clk,           // core clock
   input  wire  logic                       rst,           // sync reset
   input  wire  logic                       tristate_fuse, // fuse strap
   input  wire  logic [31:0]                pin_level,     // pad levels
   input  wire  logic [31:0]                alt_out,       // periph outs
   output var   iop_pkg::iop_pad_s          pad_ctrl,      // pad drives
   output logic [31:0]                      alt_in,        // periph ins
   input  wire  logic [iop_pkg::ADDR_W-1:0] s_axi_awaddr,  // write addr
   input  wire  logic                       s_axi_awvalid, // aw valid
   output logic                             s_axi_awready, // aw ready
   input  wire  logic [31:0]                s_axi_wdata,   // write data
   input  wire  logic [3:0]                 s_axi_wstrb,   // byte lanes
   input  wire  logic                       s_axi_wvalid,  // w valid
   output logic                             s_axi_wready,  // w ready
   output logic [1:0]                       s_axi_bresp,   // write resp
   output logic                             s_axi_bvalid,  // b valid
   input  wire  logic                       s_axi_bready,  // b ready
   input  wire  logic [iop_pkg::ADDR_W-1:0] s_axi_araddr,  // read addr
   input  wire  logic                       s_axi_arvalid, // ar valid
   output logic                             s_axi_arready, // ar ready
   output logic [31:0]                      s_axi_rdata,   // read data
   output logic [1:0]                       s_axi_rresp,   // read resp
   output logic                             s_axi_rvalid,  // r valid
   input  wire  logic                       s_axi_rready   // r ready
);

   // ********************************************************
   // Functions
   // ********************************************************

   // Decodes a byte address into a register kind; reg_port gives the port number.
   function automatic iop_pkg::iop_kind_e reg_kind(
      input logic [iop_pkg::ADDR_W-1:0] a);
      logic [7:0] idx;
      idx = a[9:2];
      case (idx)
         iop_pkg::IDX_P1_LATCH, iop_pkg::IDX_P2_LATCH,
         iop_pkg::IDX_P3_LATCH, iop_pkg::IDX_P4_LATCH:
            reg_kind = iop_pkg::KIND_LATCH;
         iop_pkg::IDX_P1_MODE_LO, iop_pkg::IDX_P2_MODE_LO,
         iop_pkg::IDX_P3_MODE_LO, iop_pkg::IDX_P4_MODE_LO:
            reg_kind = iop_pkg::KIND_MODE_LO;
         iop_pkg::IDX_P1_MODE_HI, iop_pkg::IDX_P2_MODE_HI,
         iop_pkg::IDX_P3_MODE_HI, iop_pkg::IDX_P4_MODE_HI:
            reg_kind = iop_pkg::KIND_MODE_HI;
         iop_pkg::IDX_CTRL:   reg_kind = iop_pkg::KIND_CTRL;
         iop_pkg::IDX_GPI_EN: reg_kind = iop_pkg::KIND_GPI;
         default:             reg_kind = iop_pkg::KIND_NONE;
      endcase
      if (a[1:0] != 2'b00 || a[11] ||
          (a[iop_pkg::ALIAS_BIT] && reg_kind != iop_pkg::KIND_LATCH))
         reg_kind = iop_pkg::KIND_NONE;
   endfunction

   // Port number 0 to 3 of a port register address.
   function automatic logic [1:0] reg_port(
      input logic [iop_pkg::ADDR_W-1:0] a);
      logic [7:0] idx;
      idx = a[9:2];
      case (idx)
         iop_pkg::IDX_P2_LATCH, iop_pkg::IDX_P2_MODE_LO,
         iop_pkg::IDX_P2_MODE_HI: reg_port = 2'd1;
         iop_pkg::IDX_P3_LATCH, iop_pkg::IDX_P3_MODE_LO,
         iop_pkg::IDX_P3_MODE_HI: reg_port = 2'd2;
         iop_pkg::IDX_P4_LATCH, iop_pkg::IDX_P4_MODE_LO,
         iop_pkg::IDX_P4_MODE_HI: reg_port = 2'd3;
         default:                 reg_port = 2'd0;
      endcase
   endfunction

   function automatic iop_pkg::iop_mode_e pin_mode(input logic lo,
                                                    input logic hi);
      case ({lo, hi})
         2'b00:   pin_mode = iop_pkg::MODE_QUASI;
         2'b01:   pin_mode = iop_pkg::MODE_PUSH_PULL;
         2'b10:   pin_mode = iop_pkg::MODE_INPUT_ONLY;
         default: pin_mode = iop_pkg::MODE_OPEN_DRAIN;
      endcase
   endfunction

   // ********************************************************
   // Storage
   // ********************************************************

   logic [31:0] latch_q;
   logic [31:0] mode_lo_q;
   logic [31:0] mode_hi_q;
   logic [7:0]  ctrl_q;
   logic [7:0]  gpi_en_q;
   logic        fuse_s1_q;
   logic        fuse_s2_q;
   logic [31:0] pin_s1_q;
   logic [31:0] pin_s2_q;
   logic [31:0] drive_prev_q;
   logic [1:0]  strong_cnt_q [32];
   logic [31:0] sensed_q;

   logic        aw_have_q;
   logic        w_have_q;
   logic [iop_pkg::ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;

   logic [31:0]       drive;
   iop_pkg::iop_pad_s pad_d;
   logic [31:0]       alt_in_d;
   logic [31:0]       strong_rise;

   // ********************************************************
   // Synchronisers
   // ********************************************************

   always_ff @(posedge clk) begin
      fuse_s1_q <= tristate_fuse;
      fuse_s2_q <= fuse_s1_q;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pin_s1_q <= 32'h0000_0000;
         pin_s2_q <= 32'h0000_0000;
      end else begin
         pin_s1_q <= pin_level;
         pin_s2_q <= pin_s1_q;
      end
   end

   // ********************************************************
   // AXI4-Lite write path
   // ********************************************************

   logic do_write;
   assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

   always_ff @(posedge clk) begin
      if (rst) begin
         aw_have_q     <= 1'b0;
         w_have_q      <= 1'b0;
         aw_addr_q     <= '0;
         w_data_q      <= 32'h0000_0000;
         w_strb_q      <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= iop_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (reg_kind(aw_addr_q) == iop_pkg::KIND_NONE) ?
                            iop_pkg::RESP_SLVERR : iop_pkg::RESP_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         latch_q   <= iop_pkg::LATCH_RST;
         mode_lo_q <= fuse_s2_q ? iop_pkg::MODE_LO_RST_TRI
                                : iop_pkg::MODE_LO_RST_QB;
         mode_hi_q <= iop_pkg::MODE_HI_RST;
         ctrl_q    <= iop_pkg::CTRL_RST;
         gpi_en_q  <= iop_pkg::GPI_EN_RST;
      end else if (do_write && w_strb_q[0]) begin
         case (reg_kind(aw_addr_q))
            iop_pkg::KIND_LATCH:
               latch_q[8*reg_port(aw_addr_q) +: 8] <= w_data_q[7:0];
            iop_pkg::KIND_MODE_LO:
               mode_lo_q[8*reg_port(aw_addr_q) +: 8] <= w_data_q[7:0];
            iop_pkg::KIND_MODE_HI:
               mode_hi_q[8*reg_port(aw_addr_q) +: 8] <= w_data_q[7:0];
            iop_pkg::KIND_CTRL: ctrl_q   <= w_data_q[7:0];
            iop_pkg::KIND_GPI:  gpi_en_q <= w_data_q[7:0];
            default: ;
         endcase
      end
   end

   // ********************************************************
   // AXI4-Lite read path
   // ********************************************************

   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= iop_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= iop_pkg::RESP_OKAY;
         s_axi_rdata   <= 32'h0000_0000;
         case (reg_kind(s_axi_araddr))
            iop_pkg::KIND_LATCH:
               s_axi_rdata[7:0] <= s_axi_araddr[iop_pkg::ALIAS_BIT] ?
                  latch_q[8*reg_port(s_axi_araddr) +: 8] :
                  sensed_q[8*reg_port(s_axi_araddr) +: 8];
            iop_pkg::KIND_MODE_LO:
               s_axi_rdata[7:0] <= mode_lo_q[8*reg_port(s_axi_araddr) +: 8];
            iop_pkg::KIND_MODE_HI:
               s_axi_rdata[7:0] <= mode_hi_q[8*reg_port(s_axi_araddr) +: 8];
            iop_pkg::KIND_CTRL: s_axi_rdata[7:0] <= ctrl_q;
            iop_pkg::KIND_GPI:  s_axi_rdata[7:0] <= gpi_en_q;
            default: s_axi_rresp <= iop_pkg::RESP_SLVERR;
         endcase
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

   // ********************************************************
   // Pad control
   // ********************************************************

   assign drive = latch_q & alt_out;

   always_comb begin
      logic               cmp_on;
      logic               pdown;
      logic               wake;
      iop_pkg::iop_mode_e m;
      cmp_on   = ctrl_q[iop_pkg::CTRL_CMP_A] || ctrl_q[iop_pkg::CTRL_CMP_B];
      pdown    = ctrl_q[iop_pkg::CTRL_PDOWN];
      wake     = 1'b0;
      m        = iop_pkg::MODE_QUASI;
      pad_d    = '0;
      alt_in_d = 32'h0000_0000;
      strong_rise = 32'h0000_0000;
      for (int i = 0; i < 32; i++) begin
         m = pin_mode(mode_lo_q[i], mode_hi_q[i]);
         wake = iop_pkg::WAKE_PIN_MASK[i] || (i < 8 && gpi_en_q[i % 8]);
         pad_d.input_en[i] = !(pdown && !wake) &&
            !(iop_pkg::ANALOG_PIN_MASK[i] && cmp_on &&
              m == iop_pkg::MODE_INPUT_ONLY);
         strong_rise[i] = drive[i] && !drive_prev_q[i];
         case (m)
            iop_pkg::MODE_QUASI: begin
               pad_d.very_weak_pu[i] = drive[i];
               pad_d.weak_pu[i] = drive[i] && pin_s2_q[i];
               pad_d.strong_pu[i] = drive[i] &&
                  (strong_rise[i] || strong_cnt_q[i] != 2'd0);
               pad_d.pull_down[i] = !drive[i];
            end
            iop_pkg::MODE_PUSH_PULL: begin
               pad_d.strong_pu[i] = drive[i];
               pad_d.pull_down[i] = !drive[i];
            end
            iop_pkg::MODE_OPEN_DRAIN: begin
               pad_d.pull_down[i] = !drive[i];
            end
            default: ;
         endcase
         alt_in_d[i] = pin_s2_q[i] && pad_d.input_en[i] &&
            (latch_q[i] || m == iop_pkg::MODE_INPUT_ONLY);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         drive_prev_q <= iop_pkg::LATCH_RST;
         for (int i = 0; i < 32; i++) strong_cnt_q[i] <= 2'd0;
      end else begin
         drive_prev_q <= drive;
         for (int i = 0; i < 32; i++) begin
            if (strong_rise[i])
               strong_cnt_q[i] <= iop_pkg::STRONG_CYCLES - 2'd1;
            else if (strong_cnt_q[i] != 2'd0)
               strong_cnt_q[i] <= strong_cnt_q[i] - 2'd1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pad_ctrl <= '0;
         alt_in   <= 32'h0000_0000;
         sensed_q <= 32'h0000_0000;
      end else begin
         pad_ctrl <= pad_d;
         alt_in   <= alt_in_d;
         sensed_q <= pin_s2_q & pad_d.input_en;
      end
   end

   // ********************************************************
   // Assertions
   // ********************************************************

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   for (genvar g = 0; g < 32; g++) begin : g_chk
      logic quasi;
      assign quasi = pin_mode(mode_lo_q[g], mode_hi_q[g]) ==
                     iop_pkg::MODE_QUASI;
      strong_two_a: assert property (
         (quasi && strong_rise[g]) ##1 (quasi && drive[g])
         |-> pad_ctrl.strong_pu[g] ##1 pad_ctrl.strong_pu[g])
         else $error("strong pull-up pulse length wrong");
      strong_end_a: assert property (
         quasi && strong_rise[g] ##1 (quasi && drive[g]) [*2]
         |=> !pad_ctrl.strong_pu[g])
         else $error("strong pull-up held too long");
      very_weak_a: assert property (
         quasi && drive[g] |=> pad_ctrl.very_weak_pu[g])
         else $error("very weak pull-up missing");
      weak_pu_a: assert property (
         pad_ctrl.weak_pu[g] |-> $past(drive[g]) && $past(pin_s2_q[g]))
         else $error("weak pull-up on without cause");
      in_only_a: assert property (
         pin_mode(mode_lo_q[g], mode_hi_q[g]) == iop_pkg::MODE_INPUT_ONLY
         |=> !pad_ctrl.strong_pu[g] && !pad_ctrl.pull_down[g] &&
             !pad_ctrl.weak_pu[g])
         else $error("input-only pin drives");
      od_pullup_a: assert property (
         pin_mode(mode_lo_q[g], mode_hi_q[g]) == iop_pkg::MODE_OPEN_DRAIN
         |=> !pad_ctrl.strong_pu[g] && !pad_ctrl.very_weak_pu[g] &&
             pad_ctrl.pull_down[g] == !$past(drive[g]))
         else $error("open-drain pin pulled up");
      pp_drive_a: assert property (
         pin_mode(mode_lo_q[g], mode_hi_q[g]) == iop_pkg::MODE_PUSH_PULL
         |=> pad_ctrl.strong_pu[g] == $past(drive[g]) &&
             pad_ctrl.pull_down[g] == !$past(drive[g]))
         else $error("push-pull drive wrong");
      quasi_low_a: assert property (
         quasi && !drive[g] |=> pad_ctrl.pull_down[g])
         else $error("quasi low not driven");
   end

   pdown_gate_a: assert property (
      ctrl_q[iop_pkg::CTRL_PDOWN]
      |=> pad_ctrl.input_en[0] == $past(gpi_en_q[0]) &&
          pad_ctrl.input_en[18] && !pad_ctrl.input_en[8])
      else $error("power-down input gating wrong");
   analog_cut_a: assert property (
      ctrl_q[iop_pkg::CTRL_CMP_A] && mode_lo_q[12] && !mode_hi_q[12]
      |=> !pad_ctrl.input_en[12])
      else $error("analog pin input not cut");
   write_late_a: assert property (
      (do_write && w_strb_q[0] && !mode_lo_q[0] &&
       aw_addr_q == {2'b00, iop_pkg::IDX_P1_LATCH, 2'b00}) ##1 alt_out[0]
      |=> pad_ctrl.pull_down[0] == !$past(w_data_q[0], 2))
      else $error("latch write did not reach pad");
   resp_one_a: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready ##1
      ((s_axi_bvalid && $stable(s_axi_bresp)) || $past(s_axi_bready)))
      else $error("write response dropped");

   quasi_pulse_c: cover property (pad_ctrl.strong_pu[0] ##2
                                  !pad_ctrl.strong_pu[0]);
   pdown_wake_c:  cover property (ctrl_q[iop_pkg::CTRL_PDOWN] &&
                                  pad_ctrl.input_en[0]);
   alias_read_c:  cover property (s_axi_arvalid && s_axi_arready &&
                                  s_axi_araddr[iop_pkg::ALIAS_BIT]);
   od_analog_c:   cover property (ctrl_q[iop_pkg::CTRL_CMP_A] &&
                                  pad_ctrl.input_en[12]);

endmodule

`default_nettype wire

//--- verification/iop_pins.sv
// External board devices on the port pins.
// Assumes the port's pad controls and the shared core clock.
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Pin level model
// ****************************************
module iop_pins (
   input  wire logic              clk,     // core clock
   input  var  iop_pkg::iop_pad_s pad,     // pad drives
   input  wire logic [31:0]       ext_en,  // external drive on
   input  wire logic [31:0]       ext_val, // external level
   output logic [31:0]            level    // pin levels
);
   logic [31:0] last_q = 32'h0000_0000;
   logic [31:0] pu;
   logic [31:0] own;
   assign pu = pad.strong_pu | pad.weak_pu | pad.very_weak_pu;
   assign own = ~pad.pull_down & (pu | ~last_q);
   assign level = (ext_en & ext_val) | (~ext_en & own);
   always_ff @(posedge clk) begin
      last_q <= level;
   end
endmodule
`default_nettype wire

//--- verification/iop_port_bench.sv
// Self-checking bench for the I/O port block.
// Assumes the pin model stands on the pads.
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Bench top
// ****************************************
module iop_port_bench;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        fz = 1'b0;
   logic [11:0] awa = '0;
   logic [11:0] ara = '0;
   logic [31:0] wd = '0;
   logic [31:0] xe = '0;
   logic [31:0] xv = '0;
   logic [31:0] ao = 32'hFFFF_FFFF;
   logic        awv = 1'b0;
   logic        wv = 1'b0;
   logic        br = 1'b0;
   logic        arv = 1'b0;
   logic        rr = 1'b0;
   logic        awr, wr, bv, arr, rv;
   logic [1:0]  bres, rres, rs;
   logic [31:0] pl, ai, rdata, rd, ev;
   logic [7:0]  lo, hi, lt, q, pp, inp;
   iop_pkg::iop_pad_s pc;
   int seed = 32'h47f7_3a98;
   int mismatches = 0;
   int n_checks = 0;
   int cyc = 0;
   int sc = 0;
   int sb = 0;
   iop_port dut (.clk(clk), .rst(rst), .tristate_fuse(fz),
      .pin_level(pl), .alt_out(ao), .pad_ctrl(pc), .alt_in(ai),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wr), .s_axi_bresp(bres), .s_axi_bvalid(bv),
      .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rres),
      .s_axi_rvalid(rv), .s_axi_rready(rr));
   iop_pins pins (.clk(clk), .pad(pc), .ext_en(xe), .ext_val(xv),
      .level(pl));
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (pc.strong_pu[0] === 1'b1) sc++;
      if (cyc == 8000) begin
         mismatches++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Pull-down expected for each mode pair and latch-side drive.
   function automatic logic [7:0] exp_pd(input logic [7:0] l,
                                         input logic [7:0] h,
                                         input logic [7:0] t);
      exp_pd = ~t & ~(l & ~h);
   endfunction
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic axw(input logic [11:0] a, input logic [31:0] d);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      do begin
         @(posedge clk);
         if (awr === 1'b1) awv <= 1'b0;
         if (wr === 1'b1) wv <= 1'b0;
      end while (bv !== 1'b1);
      br <= 1'b0;
      @(posedge clk);
   endtask
   task automatic axr(input logic [11:0] a);
      ara <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      do begin
         @(posedge clk);
         if (arr === 1'b1) arv <= 1'b0;
      end while (rv !== 1'b1);
      rd = rdata;
      rs = rres;
      rr <= 1'b0;
      @(posedge clk);
   endtask
   initial begin
      wt(16);
      rst <= 1'b0;
      wt(3);
      axr(12'h310);
      chk(rd, 32'h0000_00F0);
      axr(12'h308);
      chk(rd, 32'h0000_0000);
      axr(12'h640);
      chk(rd, 32'h0000_00FF);
      chk(pc.very_weak_pu, ~iop_pkg::ANALOG_PIN_MASK);
      axr(12'h000);
      chk({30'h0, rs}, {30'h0, iop_pkg::RESP_SLVERR});
      $display("test reset finished");
      axw(12'h240, 32'h0000_0000);
      wt(4);
      chk(pc.pull_down, 32'h0000_00FF);
      sb = sc;
      axw(12'h240, 32'h0000_00FF);
      wt(6);
      chk(sc - sb, 2);
      ev = 32'($random(seed)) & 32'h0000_00FF;
      xe <= 32'h0000_00FF;
      xv <= ev;
      wt(5);
      chk(pc.weak_pu & 32'h0000_00FF, ev);
      axr(12'h240);
      chk(rd, ev);
      axr(12'h640);
      chk(rd, 32'h0000_00FF);
      lt = 8'($random(seed));
      hi = 8'($random(seed));
      ao <= {24'hFF_FFFF, hi};
      axw(12'h240, {24'h00_0000, lt});
      wt(5);
      pp = exp_pd(8'h00, 8'h00, lt & hi);
      chk({24'h00_0000, ai[7:0]}, {24'h00_0000, ev[7:0] & lt});
      chk({24'h00_0000, pc.pull_down[7:0]}, {24'h00_0000, pp});
      ao <= 32'hFFFF_FFFF;
      xe <= 32'h0000_0000;
      $display("test quasi finished");
      for (int i = 0; i < 12; i++) begin
         lo = 8'($random(seed));
         hi = 8'($random(seed));
         lt = 8'($random(seed));
         axw(12'h318, {24'h0, lo});
         axw(12'h31C, {24'h0, hi});
         axw(12'h2C0, {24'h0, lt});
         wt(5);
         q = ~lo & ~hi;
         pp = ~lo & hi;
         inp = exp_pd(lo, hi, lt);
         chk({24'h00_0000, pc.strong_pu[23:16]}, {24'h00_0000, pp & lt});
         chk({24'h00_0000, pc.weak_pu[23:16]}, {24'h00_0000, q & lt});
         chk({24'h00_0000, pc.very_weak_pu[23:16]}, {24'h00_0000, q & lt});
         chk({24'h00_0000, pc.pull_down[23:16]}, {24'h00_0000, inp});
      end
      $display("test modes finished");
      axw(12'h344, 32'h0000_0001);
      axw(12'h340, 32'h0000_0004);
      wt(4);
      chk(pc.input_en, iop_pkg::WAKE_PIN_MASK | 32'h0000_0001);
      axw(12'h340, 32'h0000_0001);
      wt(4);
      chk(pc.input_en, ~iop_pkg::ANALOG_PIN_MASK);
      axw(12'h314, 32'h0000_0010);
      wt(4);
      chk(pc.input_en, ~32'h0000_E000);
      $display("test gating finished");
      fz <= 1'b1;
      rst <= 1'b1;
      wt(4);
      rst <= 1'b0;
      wt(3);
      axr(12'h308);
      chk(rd, 32'h0000_00FF);
      chk(pc.very_weak_pu, 32'h0000_0000);
      $display("test fuse finished");
      print_verdict();
   end
endmodule
`default_nettype wire
